/* logic/dsl_pkg.sv */
/*
 * Shared constants and types for the display strobe and LED readout block.
 * Assumes one 200 MHz clock domain and processor bus pins that are asynchronous to it.
 */
package dsl_pkg;

    // ****************************************************************
    // Widths and counts
    // ****************************************************************
    localparam int DSL_DATA_W = 8;
    localparam int DSL_SEL_W = 3;
    localparam int DSL_STROBES = 8;
    localparam int DSL_NUM_DIGITS = 4;
    localparam int DSL_SEG_W = 7;
    localparam int DSL_SYNC_STAGES = 3;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int DSL_ADDR_BIT_SIX = 6;
    localparam int DSL_BCD_LSB = 0;
    localparam int DSL_BCD_MSB = 3;
    localparam int DSL_SCALE_LSB = 5;
    localparam int DSL_SCALE_MSB = 7;
    localparam int DSL_DP_BIT = 4;
    localparam int DSL_DIGIT_LSB = 0;
    localparam int DSL_DIGIT_MSB = 3;

    // ****************************************************************
    // Strobe codes on the captured low address bits
    // ****************************************************************
    localparam logic [2:0] DSL_CODE_PANEL_CTRL = 3'h0;
    localparam logic [2:0] DSL_CODE_CTRL_REG = 3'h1;
    localparam logic [2:0] DSL_CODE_MODE_SW = 3'h2;
    localparam logic [2:0] DSL_CODE_SETTING_SW = 3'h3;
    localparam logic [2:0] DSL_CODE_DIGIT = 3'h4;
    localparam logic [2:0] DSL_CODE_SEGMENT = 3'h5;
    localparam logic [2:0] DSL_CODE_SERVICE_SW = 3'h0;

    // ****************************************************************
    // Values after reset
    // ****************************************************************
    localparam logic [7:0] DSL_CTRL_RESET = 8'h00;
    // Blank code, so the readout stays dark out of reset
    localparam logic [7:0] DSL_BCD_RESET = 8'h0f;
    localparam logic [7:0] DSL_DIGIT_RESET = 8'h00;
    localparam logic [7:0] DSL_ADDR_RESET = 8'h00;
    localparam logic [6:0] DSL_SEG_BLANK = 7'h00;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef struct packed {
        logic [2:0] scale;
        logic       decimalPoint;
        logic [3:0] digits;
    } dsl_digit_scale_t;

    typedef struct packed {
        logic       ale;
        logic       ioStrobe_n;
        logic       highAddrLineA;
        logic [7:0] ad;
        logic [7:0] mode;
        logic [7:0] setting;
        logic [7:0] service;
    } dsl_pins_t;

    typedef struct packed {
        logic panelCtrl;
        logic ctrlReg;
        logic modeRead;
        logic settingRead;
        logic digitLatch;
        logic segmentLatch;
        logic serviceRead;
    } dsl_strobes_t;

    localparam dsl_pins_t DSL_PINS_RESET = '{
        ale: 1'b0,
        ioStrobe_n: 1'b1,
        highAddrLineA: 1'b0,
        ad: 8'h00,
        mode: 8'h00,
        setting: 8'h00,
        service: 8'h00
    };

endpackage : dsl_pkg

/* logic/dsl_strobe_decoder.sv */
/*
 * One 3-to-8 strobe decoder with an active-low and an active-high enable.
 * Assumes select and enables come from registers of the same clock.
 */
`timescale 1ns/1ps

module dsl_strobe_decoder
    import dsl_pkg::*;
#(
    parameter int SEL_W = DSL_SEL_W
)
(
    input wire logic [SEL_W-1:0] sel,
    input wire logic enable_n,
    input wire logic enable,
    output logic [(2**SEL_W)-1:0] strobe
);

    // ****************************************************************
    // Decode
    // ****************************************************************
    always_comb
    begin
        strobe = '0;
        if (!enable_n && enable)
        begin
            strobe[sel] = 1'b1;
        end
    end

endmodule : dsl_strobe_decoder

/* logic/dsl_readout.sv */
/*
 * Storage display strobe control and four digit LED readout.
 * Assumes an 8-bit multiplexed processor bus with ALE and a decoded I/O strobe,
 * all asynchronous to ref_clk, and an external driver on the shared data pins.
 */
// Function
// - Capture low address byte on ALE rise
// - Three captured bits feed two decoders
// - No strobe unless I/O strobe low
// - First decoder needs line A high
// - Second decoder needs captured bit six
// - Export low bits and I/O strobe
// - Latch two display control registers
// - Mode and setting buffers drive bus
// - Service strobe returns service switch register
// - Latch BCD code, decode to segments
// - Latch digit/scale byte on readout strobe
// - Four digits share segments, enable gated
// - Decimal point follows enabled digit
`timescale 1ns/1ps

module dsl_readout
    import dsl_pkg::*;
#(
    parameter int DATA_W = DSL_DATA_W,
    parameter int NUM_DIGITS = DSL_NUM_DIGITS
)
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic ale,
    input wire logic [DATA_W-1:0] adIn,
    output logic [DATA_W-1:0] adOut,
    output logic adOe,
    input wire logic ioStrobe_n,
    input wire logic highAddrLineA,
    input wire logic [DATA_W-1:0] modeSwitch,
    input wire logic [DATA_W-1:0] settingSwitch,
    input wire logic [DATA_W-1:0] serviceSwitch,
    output logic [DSL_STROBES-1:0] firstDecoderStrobe,
    output logic [DSL_STROBES-1:0] secondDecoderStrobe,
    output logic [DSL_SEL_W-1:0] vmodeAddr,
    output logic vmodeIoStrobe_n,
    output logic [DATA_W-1:0] firstDisplayCtrl,
    output logic [DATA_W-1:0] secondDisplayCtrl,
    output logic [DSL_SEG_W-1:0] segmentDrive,
    output logic [NUM_DIGITS-1:0] digitEnable,
    output logic decimalPoint,
    output logic [2:0] scaleSelect
);

    localparam int PINS_W = $bits(dsl_pins_t);

    // ****************************************************************
    // Functions
    // ****************************************************************
    // Segment order is g f e d c b a; codes above nine blank the digit
    function automatic logic [DSL_SEG_W-1:0] bcd_to_segments(input logic [3:0] code);
        logic [DSL_SEG_W-1:0] seg;
        seg = DSL_SEG_BLANK;
        unique case (code)
            4'h0: seg = 7'h3f;
            4'h1: seg = 7'h06;
            4'h2: seg = 7'h5b;
            4'h3: seg = 7'h4f;
            4'h4: seg = 7'h66;
            4'h5: seg = 7'h6d;
            4'h6: seg = 7'h7d;
            4'h7: seg = 7'h07;
            4'h8: seg = 7'h7f;
            4'h9: seg = 7'h6f;
            default: seg = DSL_SEG_BLANK;
        endcase
        return seg;
    endfunction : bcd_to_segments

    // ****************************************************************
    // Declarations
    // ****************************************************************
    dsl_pins_t pinsRaw;
    dsl_pins_t pins;
    logic [PINS_W-1:0] cleanBits;
    logic alePrev;
    logic aleRise;
    logic [DATA_W-1:0] addrCapture;
    logic [DATA_W-1:0] dataPrev;
    dsl_strobes_t strobes;
    dsl_strobes_t strobesPrev;
    logic [DATA_W-1:0] bcdSegmentLatch;
    dsl_digit_scale_t digitScaleLatch;
    logic [DATA_W-1:0] next_adOut;

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    assign pinsRaw = '{
        ale: ale,
        ioStrobe_n: ioStrobe_n,
        highAddrLineA: highAddrLineA,
        ad: adIn,
        mode: modeSwitch,
        setting: settingSwitch,
        service: serviceSwitch
    };

    // Bus bits only count once two stages agree, which filters one-cycle glitches
    for (genvar i = 0; i < PINS_W; i++)
    begin : g_sync
        logic [DSL_SYNC_STAGES-1:0] stage;
        always_ff @(posedge ref_clk or negedge resetn)
        begin
            if (!resetn)
            begin
                stage <= {DSL_SYNC_STAGES{DSL_PINS_RESET[i]}};
                cleanBits[i] <= DSL_PINS_RESET[i];
            end
            else
            begin
                stage <= {stage[DSL_SYNC_STAGES-2:0], pinsRaw[i]};
                if (stage[1] == stage[2])
                begin
                    cleanBits[i] <= stage[1];
                end
            end
        end
    end

    assign pins = dsl_pins_t'(cleanBits);

    // ****************************************************************
    // Address capture
    // ****************************************************************
    assign aleRise = pins.ale && !alePrev;

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            alePrev <= 1'b0;
        end
        else
        begin
            alePrev <= pins.ale;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            addrCapture <= DSL_ADDR_RESET;
        end
        else if (aleRise)
        begin
            addrCapture <= pins.ad;
        end
    end

    // ****************************************************************
    // Strobe decoders
    // ****************************************************************
    dsl_strobe_decoder #(
        .SEL_W(DSL_SEL_W)
    ) first_strobe_decoder (
        .sel(addrCapture[DSL_SEL_W-1:0]),
        .enable_n(pins.ioStrobe_n),
        .enable(pins.highAddrLineA),
        .strobe(firstDecoderStrobe)
    );

    dsl_strobe_decoder #(
        .SEL_W(DSL_SEL_W)
    ) second_strobe_decoder (
        .sel(addrCapture[DSL_SEL_W-1:0]),
        .enable_n(pins.ioStrobe_n),
        .enable(addrCapture[DSL_ADDR_BIT_SIX]),
        .strobe(secondDecoderStrobe)
    );

    always_comb
    begin
        strobes.panelCtrl = secondDecoderStrobe[DSL_CODE_PANEL_CTRL];
        strobes.ctrlReg = secondDecoderStrobe[DSL_CODE_CTRL_REG];
        strobes.modeRead = secondDecoderStrobe[DSL_CODE_MODE_SW];
        strobes.settingRead = secondDecoderStrobe[DSL_CODE_SETTING_SW];
        strobes.digitLatch = secondDecoderStrobe[DSL_CODE_DIGIT];
        strobes.segmentLatch = secondDecoderStrobe[DSL_CODE_SEGMENT];
        strobes.serviceRead = firstDecoderStrobe[DSL_CODE_SERVICE_SW];
    end

    // ****************************************************************
    // Vertical mode export
    // ****************************************************************
    assign vmodeAddr = addrCapture[DSL_SEL_W-1:0];
    assign vmodeIoStrobe_n = pins.ioStrobe_n;

    // ****************************************************************
    // Strobe history
    // ****************************************************************
    // Latches load on the strobe's trailing edge, like an edge-clocked latch,
    // using data from the last cycle the strobe was still active
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            strobesPrev <= '0;
            dataPrev <= DSL_ADDR_RESET;
        end
        else
        begin
            strobesPrev <= strobes;
            dataPrev <= pins.ad;
        end
    end

    // ****************************************************************
    // Display control registers
    // ****************************************************************
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            firstDisplayCtrl <= DSL_CTRL_RESET;
            secondDisplayCtrl <= DSL_CTRL_RESET;
        end
        else
        begin
            if (strobesPrev.ctrlReg && !strobes.ctrlReg)
                firstDisplayCtrl <= dataPrev;
            if (strobesPrev.panelCtrl && !strobes.panelCtrl)
                secondDisplayCtrl <= dataPrev;
        end
    end

    // ****************************************************************
    // Switch read-back
    // ****************************************************************
    always_comb
    begin
        next_adOut = '0;
        if (strobes.modeRead)
            next_adOut = pins.mode;
        else if (strobes.settingRead)
            next_adOut = pins.setting;
        else if (strobes.serviceRead)
            next_adOut = pins.service;
    end

    // Enable follows the strobe; data lags it by one cycle
    assign adOe = strobes.modeRead || strobes.settingRead || strobes.serviceRead;

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            adOut <= '0;
        end
        else
        begin
            adOut <= next_adOut;
        end
    end

    // ****************************************************************
    // Readout latches
    // ****************************************************************
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            bcdSegmentLatch <= DSL_BCD_RESET;
        end
        else if (strobesPrev.segmentLatch && !strobes.segmentLatch)
        begin
            bcdSegmentLatch <= dataPrev;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            digitScaleLatch <= dsl_digit_scale_t'(DSL_DIGIT_RESET);
        end
        else if (strobesPrev.digitLatch && !strobes.digitLatch)
        begin
            digitScaleLatch <= dsl_digit_scale_t'(dataPrev);
        end
    end

    // ****************************************************************
    // Segment and digit drive
    // ****************************************************************
    // Upper four BCD bits are ignored by the decoder
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            segmentDrive <= DSL_SEG_BLANK;
        end
        else
        begin
            segmentDrive <= bcd_to_segments(bcdSegmentLatch[DSL_BCD_MSB:DSL_BCD_LSB]);
        end
    end

    // Point shares the digit enables, so it lights only on the selected digit
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            digitEnable <= '0;
            scaleSelect <= '0;
            decimalPoint <= 1'b0;
        end
        else
        begin
            digitEnable <= digitScaleLatch.digits;
            scaleSelect <= digitScaleLatch.scale;
            decimalPoint <= digitScaleLatch.decimalPoint && (|digitScaleLatch.digits);
        end
    end

endmodule : dsl_readout

/* verif/dsl_readout_props.sv */
/* Port checker for dsl_readout.
   Assumes binding into every dsl_readout instance. */
`timescale 1ns/1ps
module dsl_readout_props
    import dsl_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [7:0] adOut,
    input wire logic adOe,
    input wire logic [7:0] firstDecoderStrobe,
    input wire logic [7:0] secondDecoderStrobe,
    input wire logic [2:0] vmodeAddr,
    input wire logic vmodeIoStrobe_n,
    input wire logic [7:0] firstDisplayCtrl,
    input wire logic [7:0] secondDisplayCtrl,
    input wire logic [6:0] segmentDrive,
    input wire logic [3:0] digitEnable,
    input wire logic decimalPoint
);
    // ****************
    // Checks
    // ****************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    a_idle_no_strobe: assert property (vmodeIoStrobe_n |-> !(|firstDecoderStrobe) && !(|secondDecoderStrobe))
        else $error("strobe while io strobe idle");
    a_first_sel_match: assert property (|firstDecoderStrobe |-> firstDecoderStrobe == 8'h01 << vmodeAddr)
        else $error("first decoder strobe off select");
    a_second_sel_match: assert property (|secondDecoderStrobe |-> secondDecoderStrobe == 8'h01 << vmodeAddr)
        else $error("second decoder strobe off select");
    a_oe_read_strobe: assert property (adOe == (secondDecoderStrobe[DSL_CODE_MODE_SW] ||
        secondDecoderStrobe[DSL_CODE_SETTING_SW] || firstDecoderStrobe[DSL_CODE_SERVICE_SW]))
        else $error("bus enable without read strobe");
    a_bus_released: assert property (!adOe && !$past(adOe) |-> adOut == 8'h00)
        else $error("read data left on bus");
    // Trailing edge latching: value may only move just after the strobe ends
    a_ctrl_after_strobe: assert property ($changed(firstDisplayCtrl) |-> !$past(secondDecoderStrobe[1]) &&
        ($past(secondDecoderStrobe[1], 2) || $past(secondDecoderStrobe[1], 3)))
        else $error("control register moved without strobe");
    a_panel_after_strobe: assert property ($changed(secondDisplayCtrl) |-> !$past(secondDecoderStrobe[0]) &&
        ($past(secondDecoderStrobe[0], 2) || $past(secondDecoderStrobe[0], 3)))
        else $error("panel register moved without strobe");
    a_seg_after_strobe: assert property ($changed(segmentDrive) |-> !$past(secondDecoderStrobe[5]) &&
        ($past(secondDecoderStrobe[5], 3) || $past(secondDecoderStrobe[5], 4)))
        else $error("segments moved without strobe");
    a_digit_after_strobe: assert property ($changed(digitEnable) |-> !$past(secondDecoderStrobe[4]) &&
        ($past(secondDecoderStrobe[4], 3) || $past(secondDecoderStrobe[4], 4)))
        else $error("digit enables moved without strobe");
    a_dp_needs_digit: assert property (decimalPoint |-> |digitEnable)
        else $error("decimal point with no digit");
endmodule : dsl_readout_props

bind dsl_readout dsl_readout_props u_props (.ref_clk(ref_clk), .resetn(resetn), .adOut(adOut), .adOe(adOe),
    .firstDecoderStrobe(firstDecoderStrobe), .secondDecoderStrobe(secondDecoderStrobe), .vmodeAddr(vmodeAddr),
    .vmodeIoStrobe_n(vmodeIoStrobe_n), .firstDisplayCtrl(firstDisplayCtrl), .secondDisplayCtrl(secondDisplayCtrl),
    .segmentDrive(segmentDrive), .digitEnable(digitEnable), .decimalPoint(decimalPoint));

/* verif/dsl_cpu_model.sv */
/* Processor bus model for the readout pins.
   Assumes pins cross a 3 flop sync; drives on falling edges. */
`timescale 1ns/1ps
module dsl_cpu_model
(
    input wire logic ref_clk,
    input wire logic [7:0] adOut,
    output logic ale,
    output logic [7:0] ad,
    output logic ioStrobe_n,
    output logic highAddrLineA
);
    // ****************
    // Bus phases
    // ****************
    initial
    begin
        ale = 1'b0;
        ad = 8'h00;
        ioStrobe_n = 1'b1;
        highAddrLineA = 1'b0;
    end

    task automatic phase(input logic [7:0] a, input logic l, input logic s, input logic h, input int n);
        @(negedge ref_clk);
        ad = a;
        ale = l;
        ioStrobe_n = s;
        highAddrLineA = h;
        repeat (n) @(posedge ref_clk);
    endtask : phase

    // Long phases, since the sync eats up to four edges
    task automatic bus_write(input logic [7:0] addr, input logic h, input logic [7:0] d);
        phase(addr, 1'b1, 1'b1, h, 5);
        phase(d, 1'b0, 1'b1, h, 5);
        phase(d, 1'b0, 1'b0, h, 8);
        phase(d, 1'b0, 1'b1, h, 8);
        phase(~d, 1'b0, 1'b1, 1'b0, 1);
    endtask : bus_write

    // Released bus shows inverse, never a stale value
    task automatic bus_read(input logic [7:0] addr, input logic h, output logic [7:0] d);
        phase(addr, 1'b1, 1'b1, h, 5);
        phase(~addr, 1'b0, 1'b0, h, 8);
        // Take read data away from the edge that launches it
        @(negedge ref_clk);
        d = adOut;
        phase(~addr, 1'b0, 1'b1, h, 8);
    endtask : bus_read
endmodule : dsl_cpu_model

/* verif/dsl_readout_tb.sv */
/* Self-checking bench for dsl_readout.
   Assumes the processor model drives the bus pins. */
`timescale 1ns/1ps
module dsl_readout_tb;
    import dsl_pkg::*;
    localparam logic [6:0] SEG_MAP [10] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d, 7'h07, 7'h7f, 7'h6f};
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic ale, ioStrobe_n, highAddrLineA, adOe, vmodeIoStrobe_n, decimalPoint, bit6, dp;
    logic [7:0] cpuAd, adBus, adOut, modeSwitch, settingSwitch, serviceSwitch, rd, d;
    logic [7:0] firstDisplayCtrl, secondDisplayCtrl, firstDecoderStrobe, secondDecoderStrobe;
    logic [7:0] ctrlModel [2] = '{8'h00, 8'h00};
    logic [2:0] vmodeAddr, scaleSelect, code, sc;
    logic [6:0] segmentDrive;
    logic [3:0] digitEnable;
    int n_errors = 0;
    int checks = 0;

    always #2.5 ref_clk = ~ref_clk;
    // Shared pins: device wins while it drives
    assign adBus = adOe ? adOut : cpuAd;

    dsl_readout u_dsl_readout (.ref_clk(ref_clk), .resetn(resetn), .ale(ale), .adIn(adBus), .adOut(adOut),
        .adOe(adOe), .ioStrobe_n(ioStrobe_n), .highAddrLineA(highAddrLineA), .modeSwitch(modeSwitch),
        .settingSwitch(settingSwitch), .serviceSwitch(serviceSwitch), .firstDecoderStrobe(firstDecoderStrobe),
        .secondDecoderStrobe(secondDecoderStrobe), .vmodeAddr(vmodeAddr), .vmodeIoStrobe_n(vmodeIoStrobe_n),
        .firstDisplayCtrl(firstDisplayCtrl), .secondDisplayCtrl(secondDisplayCtrl),
        .segmentDrive(segmentDrive), .digitEnable(digitEnable), .decimalPoint(decimalPoint),
        .scaleSelect(scaleSelect));

    dsl_cpu_model u_dsl_cpu_model (.ref_clk(ref_clk), .adOut(adOut), .ale(ale), .ad(cpuAd),
        .ioStrobe_n(ioStrobe_n), .highAddrLineA(highAddrLineA));

    // ****************
    // Helpers
    // ****************
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic finish_test;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : finish_test

    // ****************
    // Tests
    // ****************
    initial
    begin
        #100000;
        n_errors++;
        finish_test();
    end

    initial
    begin
        modeSwitch = 8'h00;
        settingSwitch = 8'h00;
        serviceSwitch = 8'h00;
        void'($urandom(31637));
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        resetn = 1'b1;
        check(firstDisplayCtrl, DSL_CTRL_RESET);
        check({1'b0, segmentDrive}, {1'b0, DSL_SEG_BLANK});
        check({7'h00, vmodeIoStrobe_n}, 8'h01);
        $display("reset test done");
        // Third and fourth passes miss decoder two
        for (int k = 0; k < 6; k++)
        begin
            d = 8'($urandom);
            code = k[0] ? DSL_CODE_CTRL_REG : DSL_CODE_PANEL_CTRL;
            bit6 = (k < 2 || k > 3);
            u_dsl_cpu_model.bus_write({1'b0, bit6, 3'h0, code}, k > 1 && k < 4, d);
            if (bit6)
                ctrlModel[k[0]] = d;
            check({5'h00, vmodeAddr}, {5'h00, code});
            check(firstDisplayCtrl, ctrlModel[1]);
            check(secondDisplayCtrl, ctrlModel[0]);
        end
        $display("control test done");
        // Two polls with switches moved between them
        repeat (2)
        begin
            @(negedge ref_clk);
            modeSwitch = 8'($urandom);
            settingSwitch = 8'($urandom);
            serviceSwitch = 8'($urandom);
            u_dsl_cpu_model.bus_read({5'h08, DSL_CODE_MODE_SW}, 1'b0, rd);
            check(rd, modeSwitch);
            u_dsl_cpu_model.bus_read({5'h08, DSL_CODE_SETTING_SW}, 1'b0, rd);
            check(rd, settingSwitch);
            u_dsl_cpu_model.bus_read({5'h00, DSL_CODE_SERVICE_SW}, 1'b1, rd);
            check(rd, serviceSwitch);
            u_dsl_cpu_model.bus_read({5'h00, DSL_CODE_SERVICE_SW}, 1'b0, rd);
            check(rd, 8'h00);
        end
        $display("switch test done");
        // Blank, load code, then enable one digit
        for (int v = 0; v < 16; v++)
        begin
            sc = 3'($urandom);
            dp = 1'($urandom);
            u_dsl_cpu_model.bus_write({5'h08, DSL_CODE_DIGIT}, 1'b0, {sc, dp, 4'h0});
            check({4'h0, digitEnable}, 8'h00);
            u_dsl_cpu_model.bus_write({5'h08, DSL_CODE_SEGMENT}, 1'b0, {4'($urandom), 4'(v)});
            u_dsl_cpu_model.bus_write({5'h08, DSL_CODE_DIGIT}, 1'b0, {sc, dp, 4'h1 << (v % 4)});
            check({1'b0, segmentDrive}, {1'b0, (v < 10) ? SEG_MAP[v] : DSL_SEG_BLANK});
            check({4'h0, digitEnable}, 8'h01 << (v % 4));
            check({5'h00, scaleSelect}, {5'h00, sc});
            check({7'h00, decimalPoint}, {7'h00, dp});
        end
        $display("readout test done");
        finish_test();
    end
endmodule : dsl_readout_tb
